//--- rtl/sfe_erase_ctrl.sv
// Erase, program and suspend/resume command sequencer of a serial NOR flash
// Summary of operation
// - Subsector erase clears its whole subsector to FFh; any inner address selects it.
// - Each address bit is captured on a rising serial clock edge.
// - Accepted erases start at chip select rise and run self-timed for their duration.
// - With write enable latch clear, an erase is ignored and no flag is set.
// - While erasing, write-in-progress is one and the latch is cleared.
// - An erase timeout clears the latch and sets the erase error flag.
// - Chip select rising off the byte boundary: no erase, no flags, latch kept.
// - Erase to a protected region is refused; latch kept; flags 1 and 5 set.
// - Sector erase clears its whole sector; any inner address selects it.
// - Bulk erase takes no address; refused with flags 1 and 5 if any sector locked.
// - Suspend during program sets flag 2 now and flag 7 after the latency.
// - Suspend during erase sets flag 6 now and flag 7 after the latency.
// - If less time remains than the latency, finish instead and clear flag 2 or 6.
// - Suspend state is volatile; flag status comes up as 80h.
// - During erase suspend, other sectors accept program; suspended region reads undefined.
// - Program to the erase-suspended region is ignored, sets flag 4, latch unchanged.
// - Resume sets write-in-progress, clears ready; ignored when nothing is suspended.
// - One nesting level: first resume restarts the program, second the erase.
`timescale 1ns/100ps
`include "sfe_cfg.svh"
module sfe_erase_ctrl #(
   parameter int         ADDR_W    = 24,
   parameter int         CW        = 32,
   parameter int         SUB_CYC   = 10000,     // subsector_erase_time in cycles
   parameter int         SECT_CYC  = 40000,     // sector_erase_time in cycles
   parameter int         BULK_CYC  = 200000,    // bulk_erase_time in cycles
   parameter int         PROG_CYC  = 2000,
   parameter int         TOUT_CYC  = 20000,
   parameter logic [7:0] OP_SUB    = 8'h20,
   parameter logic [7:0] OP_SECT   = 8'hD8,
   parameter logic [7:0] OP_BULK   = 8'hC7,
   parameter logic [7:0] OP_PROG   = 8'h02,
   parameter logic [7:0] OP_SUSP   = 8'h75,
   parameter logic [7:0] OP_RESUME = 8'h7A,
   parameter logic [7:0] OP_CLRFSR = 8'h50
) (
   // Clock and reset
   input  wire logic                          clk_sys_in,
   input  wire logic                          rst_in,
   // Serial link pins, asynchronous to clk_sys_in
   input  wire logic                          cs_n_in,
   input  wire logic                          sclk_in,
   input  wire logic                          serial_line_zero_in,
   // Protection and array answers
   input  wire logic [(1<<(ADDR_W-16))-1:0]   sector_lock_in,
   input  wire logic                          array_ok_in,
   input  wire logic [ADDR_W-1:0]             rd_addr_in,
   // Array commands
   output logic                               erase_start_out,
   output logic [ADDR_W-1:0]                  erase_base_out,
   output logic [1:0]                         erase_kind_out,
   output logic                               prog_start_out,
   output logic [ADDR_W-1:0]                  prog_addr_out,
   output logic [1:0]                         array_pause_out,
   output logic                               rd_undef_out,
   // Status
   output logic [7:0]                         status_out,
   output logic [7:0]                         flag_status_out
);

   localparam int         NSECT     = 1 << (ADDR_W - 16);
   localparam logic [15:0] ADDR_BITS = 16'(`SFE_CMD_BITS + ADDR_W);

   typedef struct packed {
      logic                        sclk_m, sclk_s, sclk_d;
      logic                        cs_m, cs_s, cs_d;
      logic                        si_m, si_s;
      logic [7:0]                  opcode;
      logic [ADDR_W-1:0]           addr;
      logic [15:0]                 bits;
      logic                        wel;
      logic [7:0]                  fsr;
      sfe_pkg::sfe_slot_st_t [1:0] st;
      logic [ADDR_W-1:0]           ebase;
      sfe_pkg::sfe_kind_t          ekind;
      logic [ADDR_W-1:0]           paddr;
      logic [15:0]                 lat;
      logic                        erase_go, prog_go, rd_undef;
      logic [1:0]                  pause;
   } sfe_state_t;

   sfe_state_t r_reg;
   sfe_state_t r_next;
   sfe_tmr_if #(.CW(CW)) tmr ();

   // ==========================================================
   // Helpers
   function automatic logic [ADDR_W-1:0] span_mask(input sfe_pkg::sfe_kind_t k);
      logic [ADDR_W-1:0] m;
      m = '1;
      if (k == sfe_pkg::SFE_K_SUB) begin
         m = ADDR_W'((1 << `SFE_SUB_SPAN) - 1);
      end else if (k == sfe_pkg::SFE_K_SECT) begin
         m = ADDR_W'((1 << `SFE_SECT_SPAN) - 1);
      end
      return m;
   endfunction

   function automatic logic locked(input logic [ADDR_W-1:0] a,
                                   input logic [NSECT-1:0]  lk);
      return lk[a[ADDR_W-1:16]];
   endfunction

   function automatic logic in_region(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] base,
                                      input sfe_pkg::sfe_kind_t k);
      return (a & ~span_mask(k)) == base;
   endfunction

   // Slot 0 is the erase, slot 1 the program
   function automatic int susp_bit(input int s);
      return (s == 0) ? `SFE_FSR_ESUS : `SFE_FSR_PSUS;
   endfunction

   function automatic int err_bit(input int s);
      return (s == 0) ? `SFE_FSR_EERR : `SFE_FSR_PERR;
   endfunction

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic sclk_rise;
      logic cs_rise;
      logic busy;
      logic act;
      int   ss;
      sfe_pkg::sfe_kind_t kd;
      r_next       = r_reg;
      tmr.load     = '0;
      tmr.run      = '0;
      tmr.load_val = '0;
      ss           = 0;
      kd           = sfe_pkg::SFE_K_SUB;
      act          = 1'b0;
      busy         = 1'b0;
      sclk_rise    = r_reg.sclk_s & ~r_reg.sclk_d;
      cs_rise      = r_reg.cs_s & ~r_reg.cs_d;

      // Pins pass two flops; clock and select edges compare the second stage with a third, delayed flop
      r_next.sclk_m = sclk_in;
      r_next.sclk_s = r_reg.sclk_m;
      r_next.sclk_d = r_reg.sclk_s;
      r_next.cs_m   = cs_n_in;
      r_next.cs_s   = r_reg.cs_m;
      r_next.cs_d   = r_reg.cs_s;
      r_next.si_m   = serial_line_zero_in;
      r_next.si_s   = r_reg.si_m;
      r_next.erase_go = 1'b0;
      r_next.prog_go  = 1'b0;

      // Shift in code then address while selected
      if (~r_reg.cs_s & r_reg.cs_d) begin
         r_next.bits = '0;
      end else if (~r_reg.cs_s && sclk_rise) begin
         if (r_reg.bits < 16'(`SFE_CMD_BITS)) begin
            r_next.opcode = {r_reg.opcode[6:0], r_reg.si_s};
         end else if (r_reg.bits < ADDR_BITS) begin
            r_next.addr = {r_reg.addr[ADDR_W-2:0], r_reg.si_s};
         end
         if (r_reg.bits != '1) begin
            r_next.bits = r_reg.bits + 16'h0001;
         end
      end

      // Error clear goes first so a same-cycle error set wins
      if (cs_rise && r_reg.opcode == OP_CLRFSR && r_reg.bits == 16'(`SFE_CMD_BITS)) begin
         r_next.fsr[`SFE_FSR_PROT] = 1'b0;
         r_next.fsr[`SFE_FSR_PERR] = 1'b0;
         r_next.fsr[`SFE_FSR_EERR] = 1'b0;
      end

      // Slot sequencing: run, latency, suspended, completion check
      for (int s = 0; s < 2; s++) begin
         case (r_reg.st[s])
            sfe_pkg::SFE_RUN, sfe_pkg::SFE_LAT: begin
               tmr.run[s] = 1'b1;
               if (tmr.left[s] == '0) begin
                  r_next.fsr[susp_bit(s)] = 1'b0;
                  if (array_ok_in) begin
                     r_next.st[s] = sfe_pkg::SFE_IDLE;
                  end else begin
                     r_next.st[s]       = sfe_pkg::SFE_CHK;
                     tmr.load[s]        = 1'b1;
                     tmr.load_val[s]    = CW'(TOUT_CYC);
                  end
               end else if (r_reg.st[s] == sfe_pkg::SFE_LAT) begin
                  r_next.lat = r_reg.lat - 16'h0001;
                  if (r_reg.lat == 16'h0001) begin
                     r_next.st[s] = sfe_pkg::SFE_SUSP;
                  end
               end
            end
            sfe_pkg::SFE_CHK: begin
               tmr.run[s] = 1'b1;
               if (array_ok_in) begin
                  r_next.st[s] = sfe_pkg::SFE_IDLE;
               end else if (tmr.left[s] == '0) begin
                  r_next.st[s]           = sfe_pkg::SFE_IDLE;
                  r_next.wel             = 1'b0;
                  r_next.fsr[err_bit(s)] = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end

      for (int s = 0; s < 2; s++) begin
         if (r_next.st[s] inside {sfe_pkg::SFE_RUN, sfe_pkg::SFE_LAT, sfe_pkg::SFE_CHK}) begin
            busy = 1'b1;
         end
      end

      // Commands take effect at chip select rise
      if (cs_rise) begin
         if (r_reg.opcode == `SFE_OP_WREN && r_reg.bits == 16'(`SFE_CMD_BITS)) begin
            r_next.wel = 1'b1;
         end else if (r_reg.opcode == `SFE_OP_WRDI && r_reg.bits == 16'(`SFE_CMD_BITS)) begin
            r_next.wel = 1'b0;
         end else if (r_reg.opcode == OP_SUB || r_reg.opcode == OP_SECT || r_reg.opcode == OP_BULK) begin
            kd = (r_reg.opcode == OP_SUB)  ? sfe_pkg::SFE_K_SUB :
                 (r_reg.opcode == OP_SECT) ? sfe_pkg::SFE_K_SECT : sfe_pkg::SFE_K_BULK;
            // Off-boundary framing or a clear latch: nothing at all
            if (r_reg.bits == ((kd == sfe_pkg::SFE_K_BULK) ? 16'(`SFE_CMD_BITS) : ADDR_BITS)
                && r_reg.wel && !busy
                && r_next.st[0] == sfe_pkg::SFE_IDLE && r_next.st[1] == sfe_pkg::SFE_IDLE) begin
               if ((kd == sfe_pkg::SFE_K_BULK) ? (|sector_lock_in)
                                               : locked(r_reg.addr, sector_lock_in)) begin
                  r_next.fsr[`SFE_FSR_PROT] = 1'b1;
                  r_next.fsr[`SFE_FSR_EERR] = 1'b1;
               end else begin
                  r_next.st[0]       = sfe_pkg::SFE_RUN;
                  r_next.wel         = 1'b0;
                  r_next.ekind       = kd;
                  r_next.ebase       = r_reg.addr & ~span_mask(kd);
                  r_next.erase_go    = 1'b1;
                  busy               = 1'b1;
                  tmr.load[0]        = 1'b1;
                  tmr.load_val[0]    = (kd == sfe_pkg::SFE_K_SUB)  ? CW'(SUB_CYC) :
                                       (kd == sfe_pkg::SFE_K_SECT) ? CW'(SECT_CYC) : CW'(BULK_CYC);
               end
            end
         end else if (r_reg.opcode == OP_PROG) begin
            if (r_reg.bits >= ADDR_BITS + 16'h0008 && r_reg.bits[2:0] == 3'h0
                && r_reg.wel && !busy && r_next.st[1] == sfe_pkg::SFE_IDLE) begin
               if (r_next.st[0] == sfe_pkg::SFE_SUSP
                   && in_region(r_reg.addr, r_reg.ebase, r_reg.ekind)) begin
                  r_next.fsr[`SFE_FSR_PERR] = 1'b1;
               end else if (locked(r_reg.addr, sector_lock_in)) begin
                  r_next.fsr[`SFE_FSR_PROT] = 1'b1;
                  r_next.fsr[`SFE_FSR_PERR] = 1'b1;
               end else begin
                  r_next.st[1]    = sfe_pkg::SFE_RUN;
                  r_next.wel      = 1'b0;
                  r_next.paddr    = r_reg.addr;
                  r_next.prog_go  = 1'b1;
                  busy            = 1'b1;
                  tmr.load[1]     = 1'b1;
                  tmr.load_val[1] = CW'(PROG_CYC);
               end
            end
         end else if (r_reg.opcode == OP_SUSP && r_reg.bits == 16'(`SFE_CMD_BITS)) begin
            // Only a running operation can be suspended
            if (r_next.st[1] == sfe_pkg::SFE_RUN) begin
               ss  = 1;
               act = 1'b1;
            end else if (r_next.st[0] == sfe_pkg::SFE_RUN) begin
               ss  = 0;
               act = 1'b1;
            end
            if (act) begin
               r_next.fsr[susp_bit(ss)] = 1'b1;
               if (tmr.left[ss] >= CW'((ss == 1) ? `SFE_SLAT_PROG_CYC : `SFE_SLAT_ERASE_CYC)) begin
                  r_next.st[ss] = sfe_pkg::SFE_LAT;
                  r_next.lat    = 16'((ss == 1) ? `SFE_SLAT_PROG_CYC : `SFE_SLAT_ERASE_CYC);
               end
            end
         end else if (r_reg.opcode == OP_RESUME && r_reg.bits == 16'(`SFE_CMD_BITS) && !busy) begin
            // Inner program resumes before the outer erase
            if (r_next.st[1] == sfe_pkg::SFE_SUSP) begin
               r_next.st[1]              = sfe_pkg::SFE_RUN;
               r_next.fsr[`SFE_FSR_PSUS] = 1'b0;
               busy                      = 1'b1;
            end else if (r_next.st[0] == sfe_pkg::SFE_SUSP) begin
               r_next.st[0]              = sfe_pkg::SFE_RUN;
               r_next.fsr[`SFE_FSR_ESUS] = 1'b0;
               busy                      = 1'b1;
            end
         end
      end

      // Ready follows busy, so resume drops it and suspend raises it
      r_next.fsr[`SFE_FSR_READY] = ~busy;
      r_next.pause    = {r_next.st[1] == sfe_pkg::SFE_SUSP, r_next.st[0] == sfe_pkg::SFE_SUSP};
      r_next.rd_undef = (r_next.st[0] == sfe_pkg::SFE_SUSP)
                        && in_region(rd_addr_in, r_next.ebase, r_next.ekind);
   end

   // ==========================================================
   // State register; no suspend survives reset
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         r_reg      <= '0;
         r_reg.cs_m <= 1'b1;
         r_reg.cs_s <= 1'b1;
         r_reg.cs_d <= 1'b1;
         r_reg.fsr  <= `SFE_FSR_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   sfe_op_timer #(.CW(CW)) u_timer (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .tmr        (tmr.timer)
   );

   // ==========================================================
   // Outputs straight from flops
   assign erase_start_out = r_reg.erase_go;
   assign erase_base_out  = r_reg.ebase;
   assign erase_kind_out  = r_reg.ekind;
   assign prog_start_out  = r_reg.prog_go;
   assign prog_addr_out   = r_reg.paddr;
   assign array_pause_out = r_reg.pause;
   assign rd_undef_out    = r_reg.rd_undef;
   assign flag_status_out = r_reg.fsr;
   assign status_out      = {6'h00, r_reg.wel, ~r_reg.fsr[`SFE_FSR_READY]};

endmodule

//--- rtl/sfe_cfg.svh
// Constants for the serial flash erase and suspend sequencer
`ifndef SFE_CFG_SVH
`define SFE_CFG_SVH

// ==========================================================
// Status and flag status bit positions
`define SFE_SR_WIP        0
`define SFE_SR_WEL        1
`define SFE_FSR_PROT      1
`define SFE_FSR_PSUS      2
`define SFE_FSR_PERR      4
`define SFE_FSR_EERR      5
`define SFE_FSR_ESUS      6
`define SFE_FSR_READY     7
`define SFE_FSR_RESET     8'h80

// ==========================================================
// Fixed command codes and framing
`define SFE_OP_WREN       8'h06
`define SFE_OP_WRDI       8'h04
`define SFE_CMD_BITS      8
`define SFE_SUB_SPAN      12
`define SFE_SECT_SPAN     16

// ==========================================================
// Timing, least times rounded up to whole cycles
`define SFE_CLK_NS        40
`define SFE_SLAT_ERASE_NS 15000
`define SFE_SLAT_PROG_NS  7000
`define SFE_SLAT_ERASE_CYC ((`SFE_SLAT_ERASE_NS + `SFE_CLK_NS - 1) / `SFE_CLK_NS)
`define SFE_SLAT_PROG_CYC  ((`SFE_SLAT_PROG_NS + `SFE_CLK_NS - 1) / `SFE_CLK_NS)

`endif

//--- rtl/sfe_pkg.sv
// Types shared by the serial flash erase and suspend sequencer
package sfe_pkg;

   // ==========================================================
   // Per-operation slot state
   typedef enum logic [2:0] {
      SFE_IDLE,
      SFE_RUN,
      SFE_LAT,
      SFE_SUSP,
      SFE_CHK
   } sfe_slot_st_t;

   // ==========================================================
   // Erase extent
   typedef enum logic [1:0] {
      SFE_K_SUB,
      SFE_K_SECT,
      SFE_K_BULK
   } sfe_kind_t;

endpackage

//--- rtl/sfe_tmr_if.sv
// Carrier between the sequencer and its operation timers
`timescale 1ns/100ps
interface sfe_tmr_if #(parameter int CW = 32);
   logic [1:0]         load;
   logic [1:0]         run;
   logic [1:0][CW-1:0] load_val;
   logic [1:0][CW-1:0] left;

   modport ctrl  (output load, output run, output load_val, input left);
   modport timer (input load, input run, input load_val, output left);
endinterface

//--- rtl/sfe_op_timer.sv
// Two down-counters: slot 0 times erases, slot 1 times programs
`timescale 1ns/100ps
module sfe_op_timer #(
   parameter int CW = 32
) (
   // Clock and reset
   input  wire logic clk_sys_in,
   input  wire logic rst_in,
   // Control side
   sfe_tmr_if.timer  tmr
);

   typedef struct packed {
      logic [1:0][CW-1:0] cnt;
   } sfe_tmr_state_t;

   sfe_tmr_state_t r_reg;
   sfe_tmr_state_t r_next;

   // ==========================================================
   // Load wins over counting; a frozen slot keeps its remainder
   always_comb begin
      r_next = r_reg;
      for (int s = 0; s < 2; s++) begin
         if (tmr.load[s]) begin
            r_next.cnt[s] = tmr.load_val[s];
         end else if (tmr.run[s] && (r_reg.cnt[s] != '0)) begin
            r_next.cnt[s] = r_reg.cnt[s] - CW'(1);
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign tmr.left = r_reg.cnt;

endmodule

//--- tb/sfe_erase_ctrl_props.sv
// Port checker for the erase and suspend sequencer
`timescale 1ns/100ps
module sfe_erase_ctrl_props #(parameter int ADDR_W = 24) (
   // Clock and reset
   input wire logic              clk_sys_in,
   input wire logic              rst_in,
   // Link and array side
   input wire logic              cs_n_in,
   input wire logic              erase_start_out,
   input wire logic [ADDR_W-1:0] erase_base_out,
   input wire logic [1:0]        erase_kind_out,
   input wire logic [1:0]        array_pause_out,
   input wire logic              rd_undef_out,
   // Status
   input wire logic [7:0]        status_out,
   input wire logic [7:0]        flag_status_out
);
   // ==========================================================
   // Suspend age; saturates so a long suspend never wraps
   logic [8:0] lat_reg;
   logic [8:0] lat_next;
   always_comb begin
      lat_next = !flag_status_out[6] ? 9'h000 : (&lat_reg ? lat_reg : lat_reg + 9'h001);
   end
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) lat_reg <= 9'h000;
      else lat_reg <= lat_next;
   end
   // ==========================================================
   // Properties
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   property p_go_flags; erase_start_out |-> status_out[1:0] == 2'b01; endproperty
   a_go_flags: assert property (p_go_flags) else $error("start without busy");
   property p_go_pulse; erase_start_out |=> !erase_start_out; endproperty
   a_go_pulse: assert property (p_go_pulse) else $error("start pulse too long");
   property p_go_cs; erase_start_out |-> $past(cs_n_in, 1) && $past(cs_n_in, 3); endproperty
   a_go_cs: assert property (p_go_cs) else $error("start before deselect");
   property p_go_wel; erase_start_out |-> $past(status_out[1]); endproperty
   a_go_wel: assert property (p_go_wel) else $error("start without write enable");
   property p_sub_base; erase_start_out |-> erase_base_out[11:0] == 12'h000; endproperty
   a_sub_base: assert property (p_sub_base) else $error("base not 4K aligned");
   property p_sect_base; erase_start_out && erase_kind_out == 2'h1 |-> erase_base_out[15:0] == 16'h0000; endproperty
   a_sect_base: assert property (p_sect_base) else $error("base not 64K aligned");
   property p_prot; $rose(flag_status_out[1]) |-> status_out[1:0] == 2'b10; endproperty
   a_prot: assert property (p_prot) else $error("protect flag with latch lost");
   property p_tout; $rose(flag_status_out[5]) && !flag_status_out[1] |-> !status_out[1]; endproperty
   a_tout: assert property (p_tout) else $error("erase error with latch set");
   property p_done; $fell(status_out[0]) |-> flag_status_out[7]; endproperty
   a_done: assert property (p_done) else $error("idle without ready");
   property p_lat; $rose(flag_status_out[7]) && flag_status_out[6] |-> lat_reg >= 9'h172; endproperty
   a_lat: assert property (p_lat) else $error("suspend before latency");
   property p_pause; $rose(array_pause_out[0]) |-> flag_status_out[7:6] == 2'b11 && !status_out[0]; endproperty
   a_pause: assert property (p_pause) else $error("pause with wrong flags");
   property p_resume; $fell(array_pause_out[0]) |-> status_out[0] && !flag_status_out[7]; endproperty
   a_resume: assert property (p_resume) else $error("resume flags wrong");
   property p_undef; rd_undef_out |-> array_pause_out[0]; endproperty
   a_undef: assert property (p_undef) else $error("undefined read outside suspend");
   property p_rst; disable iff (1'b0) rst_in |-> flag_status_out == 8'h80 && status_out == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule

//--- tb/sfe_host_model.sv
// Behavioural serial host that frames flash commands
`timescale 1ns/100ps
module sfe_host_model (
   // Pacing clock
   input  wire logic clk_sys_in,
   // Serial link
   output logic      cs_n_out,
   output logic      sclk_out,
   output logic      sdo_out
);
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      sdo_out  = 1'b0;
   end
   // One frame, MSB first on line zero; link clock stands low outside frames
   task automatic frame(input logic [39:0] bits, input int n);
      cs_n_out = 1'b0;
      repeat (4) @(negedge clk_sys_in);
      for (int i = 0; i < n; i++) begin
         sdo_out = bits[39-i];
         repeat (4) @(negedge clk_sys_in);
         sclk_out = 1'b1;
         repeat (4) @(negedge clk_sys_in);
         sclk_out = 1'b0;
      end
      repeat (4) @(negedge clk_sys_in);
      cs_n_out = 1'b1;
      // Released line flips so a stale bit cannot pass for data
      sdo_out = ~sdo_out;
      repeat (8) @(negedge clk_sys_in);
   endtask
endmodule

//--- tb/sfe_erase_ctrl_test.sv
// Self-checking bench of the erase and suspend sequencer
`timescale 1ns/100ps
`include "sfe_cfg.svh"
module sfe_erase_ctrl_test;
   // Shortened durations keep the run small
   localparam int          SUB = 400, SECT = 500, BULK = 450, PROG = 400, TOUT = 100;
   localparam logic [7:0]  O_PROG = 8'h02, O_SUS = 8'h75, O_RES = 8'h7A, O_CLR = 8'h50;
   localparam logic [7:0]  KOP [3]  = '{8'h20, 8'hD8, 8'hC7};
   localparam logic [23:0] MASK [3] = '{24'hFFF000, 24'hFF0000, 24'h000000};
   localparam int          DUR [3]  = '{SUB, SECT, BULK};
   logic         clk_sys_in = 1'b0;
   logic         rst_in = 1'b0;
   logic         ok = 1'b1;
   logic [255:0] lock = '0;
   logic [23:0]  rd_addr = 24'h000000;
   logic [31:0]  seed = 32'h9c47;
   logic         cs_n, sclk, sdo, e_start, p_start, undef;
   logic [23:0]  base, p_addr;
   logic [1:0]   kind, pause;
   logic [7:0]   sr, fsr;
   int           fails = 0, num_checks = 0, n_start = 0, n_prog = 0, t_start = 0, cyc = 0;

   always #20 clk_sys_in = ~clk_sys_in;
   sfe_host_model sfe_host_model_i (.clk_sys_in(clk_sys_in), .cs_n_out(cs_n), .sclk_out(sclk), .sdo_out(sdo));
   sfe_erase_ctrl #(.SUB_CYC(SUB), .SECT_CYC(SECT), .BULK_CYC(BULK), .PROG_CYC(PROG), .TOUT_CYC(TOUT),
      .OP_SUB(KOP[0]), .OP_SECT(KOP[1]), .OP_BULK(KOP[2]), .OP_PROG(O_PROG), .OP_SUSP(O_SUS),
      .OP_RESUME(O_RES), .OP_CLRFSR(O_CLR)) sfe_erase_ctrl_i (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n), .sclk_in(sclk), .serial_line_zero_in(sdo),
      .sector_lock_in(lock), .array_ok_in(ok), .rd_addr_in(rd_addr), .erase_start_out(e_start),
      .erase_base_out(base), .erase_kind_out(kind), .prog_start_out(p_start), .prog_addr_out(p_addr),
      .array_pause_out(pause), .rd_undef_out(undef), .status_out(sr), .flag_status_out(fsr));

   // Launch counts reveal commands that should have been ignored
   always @(posedge clk_sys_in) begin
      cyc++;
      if (e_start === 1'b1) t_start = cyc;
      if (e_start === 1'b1) n_start++;
      if (p_start === 1'b1) n_prog++;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic op(input logic [7:0] c);
      sfe_host_model_i.frame({c, 32'h0}, 8);
   endtask
   task automatic erase(input logic [7:0] c, input logic [23:0] a, input int n);
      op(`SFE_OP_WREN);
      sfe_host_model_i.frame({c, a, 8'h00}, n);
   endtask
   // Bounded poll of bit i of {flag status, status}
   task automatic wait_bit(input int i, input logic v);
      int k;
      logic [15:0] w;
      k = 0;
      w = {fsr, sr};
      while (w[i] !== v && k < 3000) begin
         @(negedge clk_sys_in);
         w = {fsr, sr};
         k++;
      end
      chk("wait", k < 3000, 1);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      logic [23:0] a;
      int d;
      // Raised off the clock edge so the asynchronous clear fires before the first edge
      #1 rst_in = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      chk("fsr", {sr, fsr}, 16'h0080);
      rst_in = 1'b0;
      repeat (4) @(negedge clk_sys_in);
      op(`SFE_OP_WREN);
      op(`SFE_OP_WRDI);
      sfe_host_model_i.frame({KOP[0], 24'(rnd()), 8'h00}, 32);
      chk("nowel", {n_start, sr, fsr}, 48'h80);
      for (int k = 0; k < 3; k++) begin
         a = 24'(rnd());
         erase(KOP[k], a, k == 2 ? 8 : 32);
         chk("busy", {n_start, sr}, {k + 1, 8'h01});
         chk("base", {kind, base}, {k[1:0], a & MASK[k]});
         wait_bit(0, 1'b0);
         d = cyc - t_start;
         chk("time", d >= DUR[k] && d <= DUR[k] + 4, 1);
         chk("done", {sr, fsr}, 16'h0080);
      end
      a = 24'(rnd());
      erase(KOP[1], a, 31);
      chk("short", {n_start, sr, fsr}, {32'd3, 16'h0280});
      lock[a[23:16]] = 1'b1;
      for (int k = 0; k < 3; k++) begin
         erase(KOP[k], a, k == 2 ? 8 : 32);
         chk("lock", {n_start, sr, fsr}, {32'd3, 16'h02A2});
         op(O_CLR);
      end
      lock = '0;
      ok = 1'b0;
      erase(KOP[0], a, 32);
      wait_bit(0, 1'b0);
      chk("tout", {fsr[5], sr[1]}, 2'b10);
      ok = 1'b1;
      op(O_CLR);
      erase(KOP[0], a, 32);
      repeat (100) @(negedge clk_sys_in);
      op(O_SUS);
      chk("late", fsr[6], 1);
      wait_bit(0, 1'b0);
      chk("late", {pause, fsr}, 10'h080);
      erase(KOP[1], a, 32);
      op(O_SUS);
      chk("esus", fsr[7:6], 2'b01);
      wait_bit(15, 1'b1);
      chk("esus", {pause, sr, fsr}, 18'h100C0);
      rd_addr = a ^ 24'h000ABC;
      repeat (2) @(negedge clk_sys_in);
      chk("undef", undef, 1);
      rd_addr = a ^ 24'h010000;
      repeat (2) @(negedge clk_sys_in);
      chk("undef", undef, 0);
      op(`SFE_OP_WREN);
      sfe_host_model_i.frame({O_PROG, a, 8'h5A}, 40);
      chk("psame", {n_prog, fsr[4], sr[1]}, {32'd0, 2'b11});
      op(O_CLR);
      sfe_host_model_i.frame({O_PROG, a ^ 24'h010000, 8'hA5}, 40);
      chk("pother", {n_prog, p_addr}, {32'd1, a ^ 24'h010000});
      op(O_SUS);
      chk("psus", fsr[2], 1);
      wait_bit(15, 1'b1);
      chk("nest", pause, 2'b11);
      op(O_RES);
      chk("res1", {pause, sr[0], fsr[7]}, 4'b0110);
      wait_bit(0, 1'b0);
      op(O_RES);
      chk("res2", {pause, sr[0]}, 3'b001);
      wait_bit(0, 1'b0);
      op(O_RES);
      chk("idle", {pause, sr, fsr}, 18'h00080);
      conclude();
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (60000) @(posedge clk_sys_in);
      fails++;
      conclude();
   end
endmodule
bind sfe_erase_ctrl sfe_erase_ctrl_props #(.ADDR_W(ADDR_W)) sfe_erase_ctrl_props_i (.clk_sys_in, .rst_in,
   .cs_n_in, .erase_start_out, .erase_base_out, .erase_kind_out, .array_pause_out, .rd_undef_out,
   .status_out, .flag_status_out);
